/* verilog/vrc_top.sv */
// Voltage reference control register and its outputs to the analog side.
// Assumes a plain synchronous register port and enables from peer blocks.
`timescale 1ns/1ps
`include "vrc_defines.svh"

module vrc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic adcEnable,
  input wire logic oscEnable,
  output logic referenceSourceSelect,
  output logic tempSensorEnable,
  output logic biasGeneratorEnable
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic hitCtrl;
  logic wrCtrl;
  logic rdCtrl;
  assign hitCtrl = (regAddr == `VRC_ADDR_REFERENCE_CONTROL);
  assign wrCtrl = regWrEn & hitCtrl;
  assign rdCtrl = regRdEn & hitCtrl;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  vrc_pkg::vrc_byte_type ctrl_ff;
  vrc_pkg::vrc_byte_type nxt_ctrl;
  vrc_pkg::vrc_byte_type rdData_ff;
  vrc_pkg::vrc_byte_type nxt_rdData;
  vrc_pkg::vrc_byte_type readView;
  logic biasOn;

  // Unused bits masked at the write, so they never hold a one
  assign nxt_ctrl = wrCtrl ? (regWrData & `VRC_MASK_REFERENCE_CONTROL) : ctrl_ff;

  // Reset to all zero: external pin, sensor off, manual bias off
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= `VRC_RESET_REFERENCE_CONTROL;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to analog side
  // ----------------------------------------------------------------------
  assign referenceSourceSelect = ctrl_ff[`VRC_BIT_REF_SOURCE_SELECT];
  assign tempSensorEnable = ctrl_ff[`VRC_BIT_TEMP_SENSOR_ENABLE];

  // Sensor counts as a bias user too, so its own bit is a demand
  vrc_bias_force #(
    .NUM_DEMANDS(`VRC_BIAS_DEMANDS)
  ) uBiasForce (
    .manualEnable(ctrl_ff[`VRC_BIT_BIAS_GENERATOR_ENABLE]),
    .demands({adcEnable, tempSensorEnable, oscEnable}),
    .biasOn(biasOn)
  );
  assign biasGeneratorEnable = biasOn;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Bias bit reads its effective value, so a forced bias shows as one
  always_comb begin
    readView = ctrl_ff & `VRC_MASK_REFERENCE_CONTROL;
    readView[`VRC_BIT_BIAS_GENERATOR_ENABLE] = biasOn;
  end
  assign nxt_rdData = rdCtrl ? readView : `VRC_READ_IDLE;

  // Data stands one cycle after the strobe only; zero otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_ff <= `VRC_READ_IDLE;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end
  assign regRdData = rdData_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence wrSelSupply;
    wrCtrl && regWrData[`VRC_BIT_REF_SOURCE_SELECT];
  endsequence

  sequence wrSelPin;
    wrCtrl && !regWrData[`VRC_BIT_REF_SOURCE_SELECT];
  endsequence

  chk_ref_select_supply: assert property (@(posedge clk) disable iff (reset)
    wrSelSupply |=> referenceSourceSelect)
    else $error("reference select not set after write of one");

  chk_ref_select_pin: assert property (@(posedge clk) disable iff (reset)
    wrSelPin |=> !referenceSourceSelect)
    else $error("reference select not cleared after write of zero");

  chk_bias_forced_on: assert property (@(posedge clk) disable iff (reset)
    (adcEnable || oscEnable || tempSensorEnable) |-> biasGeneratorEnable)
    else $error("bias off while a dependent peripheral is enabled");

  chk_bias_manual_off: assert property (@(posedge clk) disable iff (reset)
    (wrCtrl && !regWrData[`VRC_BIT_BIAS_GENERATOR_ENABLE]) ##1
    (!adcEnable && !oscEnable && !tempSensorEnable) |-> !biasGeneratorEnable)
    else $error("bias stayed on after manual clear with no demand");

  chk_bias_manual_on: assert property (@(posedge clk) disable iff (reset)
    (wrCtrl && regWrData[`VRC_BIT_BIAS_GENERATOR_ENABLE]) |=> biasGeneratorEnable)
    else $error("bias not on after manual set");

  chk_temp_enable: assert property (@(posedge clk) disable iff (reset)
    wrCtrl |=> (tempSensorEnable == $past(regWrData[`VRC_BIT_TEMP_SENSOR_ENABLE])))
    else $error("sensor enable does not follow written bit");

  chk_unused_read_zero: assert property (@(posedge clk) disable iff (reset)
    (regRdData & ~`VRC_MASK_REFERENCE_CONTROL) == `VRC_READ_IDLE)
    else $error("unused bits read nonzero");

  chk_read_one_cycle: assert property (@(posedge clk) disable iff (reset)
    rdCtrl |=> (regRdData[`VRC_BIT_REF_SOURCE_SELECT] == referenceSourceSelect))
    else $error("read data does not show reference select");

  chk_reset_clear: assert property (@(posedge clk)
    reset |=> (!referenceSourceSelect && !tempSensorEnable && regRdData == `VRC_READ_IDLE))
    else $error("control bits not cleared by reset");

  chk_hold_value: assert property (@(posedge clk) disable iff (reset)
    !wrCtrl |=> $stable(ctrl_ff))
    else $error("control register changed without a write");

  // ----------------------------------------------------------------------
  // Checks: register port framing
  // ----------------------------------------------------------------------
  // Read data is a one-cycle pulse; anything else reads as idle
  sequence rdHit;
    rdCtrl;
  endsequence

  sequence rdIdle;
    !rdCtrl;
  endsequence

  sequence rdMiss;
    regRdEn && !hitCtrl;
  endsequence

  sequence wrMiss;
    regWrEn && !hitCtrl;
  endsequence

  chk_read_idle_zero: assert property (@(posedge clk) disable iff (reset)
    rdIdle |=> (regRdData == `VRC_READ_IDLE))
    else $error("read data not idle outside a read");

  chk_unmapped_read: assert property (@(posedge clk) disable iff (reset)
    rdMiss |=> (regRdData == `VRC_READ_IDLE))
    else $error("unmapped read returned data");

  chk_unmapped_write: assert property (@(posedge clk) disable iff (reset)
    wrMiss |=> $stable(ctrl_ff))
    else $error("unmapped write changed the register");

  chk_stored_unused_zero: assert property (@(posedge clk) disable iff (reset)
    ((ctrl_ff & ~`VRC_MASK_REFERENCE_CONTROL) == `VRC_READ_IDLE))
    else $error("unused bit stored a one");

  chk_unused_write_ignored: assert property (@(posedge clk) disable iff (reset)
    wrCtrl |=> ((ctrl_ff & ~`VRC_MASK_REFERENCE_CONTROL) == `VRC_READ_IDLE))
    else $error("write reached an unused bit");

  // Read-back sees the same bits the analog side sees
  chk_read_sensor: assert property (@(posedge clk) disable iff (reset)
    rdHit |=> (regRdData[`VRC_BIT_TEMP_SENSOR_ENABLE] == tempSensorEnable))
    else $error("read data does not show sensor enable");

  chk_read_bias: assert property (@(posedge clk) disable iff (reset)
    rdHit |=> (regRdData[`VRC_BIT_BIAS_GENERATOR_ENABLE] == $past(biasGeneratorEnable)))
    else $error("read data does not show effective bias");

  chk_write_read_select: assert property (@(posedge clk) disable iff (reset)
    wrCtrl ##1 rdHit |=> (regRdData[`VRC_BIT_REF_SOURCE_SELECT] == $past(regWrData[`VRC_BIT_REF_SOURCE_SELECT], 2)))
    else $error("select read-back differs from write");

  chk_write_read_sensor: assert property (@(posedge clk) disable iff (reset)
    wrCtrl ##1 rdHit |=> (regRdData[`VRC_BIT_TEMP_SENSOR_ENABLE] == $past(regWrData[`VRC_BIT_TEMP_SENSOR_ENABLE], 2)))
    else $error("sensor read-back differs from write");

  chk_write_read_unused: assert property (@(posedge clk) disable iff (reset)
    wrCtrl ##1 rdHit |=> ((regRdData & ~`VRC_MASK_REFERENCE_CONTROL) == `VRC_READ_IDLE))
    else $error("unused bits read back nonzero");

  chk_write_read_bias: assert property (@(posedge clk) disable iff (reset)
    (wrCtrl && regWrData[`VRC_BIT_BIAS_GENERATOR_ENABLE]) ##1 rdHit |=> regRdData[`VRC_BIT_BIAS_GENERATOR_ENABLE])
    else $error("manual bias not seen on read-back");

  // ----------------------------------------------------------------------
  // Checks: sensor and select fields
  // ----------------------------------------------------------------------
  // Fields move only on a write here; a stray change would upset the analog side
  sequence wrSensorOn;
    wrCtrl && regWrData[`VRC_BIT_TEMP_SENSOR_ENABLE];
  endsequence

  sequence wrSensorOff;
    wrCtrl && !regWrData[`VRC_BIT_TEMP_SENSOR_ENABLE];
  endsequence

  chk_sensor_on: assert property (@(posedge clk) disable iff (reset)
    wrSensorOn |=> tempSensorEnable)
    else $error("sensor not on after write of one");

  chk_sensor_off: assert property (@(posedge clk) disable iff (reset)
    wrSensorOff |=> !tempSensorEnable)
    else $error("sensor not off after write of zero");

  chk_sensor_hold: assert property (@(posedge clk) disable iff (reset)
    !wrCtrl |=> $stable(tempSensorEnable))
    else $error("sensor enable changed without a write");

  chk_select_hold: assert property (@(posedge clk) disable iff (reset)
    !wrCtrl |=> $stable(referenceSourceSelect))
    else $error("reference select changed without a write");

  // ----------------------------------------------------------------------
  // Checks: bias generator
  // ----------------------------------------------------------------------
  // Each demand alone must force the bias, so a dropped term is caught
  sequence noDemand;
    !adcEnable && !oscEnable && !tempSensorEnable;
  endsequence

  chk_bias_adc_force: assert property (@(posedge clk) disable iff (reset)
    adcEnable |-> biasGeneratorEnable)
    else $error("bias off while converter enabled");

  chk_bias_osc_force: assert property (@(posedge clk) disable iff (reset)
    oscEnable |-> biasGeneratorEnable)
    else $error("bias off while oscillator enabled");

  chk_bias_sensor_force: assert property (@(posedge clk) disable iff (reset)
    tempSensorEnable |-> biasGeneratorEnable)
    else $error("bias off while sensor enabled");

  chk_bias_force_read: assert property (@(posedge clk) disable iff (reset)
    (rdCtrl && adcEnable) |=> regRdData[`VRC_BIT_BIAS_GENERATOR_ENABLE])
    else $error("forced bias not seen on read");

  // With no demand the output is the stored manual bit, nothing more
  chk_bias_manual_hold: assert property (@(posedge clk) disable iff (reset)
    ctrl_ff[`VRC_BIT_BIAS_GENERATOR_ENABLE] |-> biasGeneratorEnable)
    else $error("bias off while manual bit set");

  chk_bias_idle_follow: assert property (@(posedge clk) disable iff (reset)
    noDemand |-> (biasGeneratorEnable == ctrl_ff[`VRC_BIT_BIAS_GENERATOR_ENABLE]))
    else $error("bias differs from manual bit with no demand");

  // ----------------------------------------------------------------------
  // Checks: reset
  // ----------------------------------------------------------------------
  // Not disabled by reset: these look at the cycle right after it
  sequence resetSeen;
    reset;
  endsequence

  chk_reset_manual_bias: assert property (@(posedge clk)
    resetSeen |=> !ctrl_ff[`VRC_BIT_BIAS_GENERATOR_ENABLE])
    else $error("manual bias not cleared by reset");

  chk_reset_select: assert property (@(posedge clk)
    resetSeen |=> !referenceSourceSelect)
    else $error("select not cleared by reset");

  chk_reset_sensor: assert property (@(posedge clk)
    resetSeen |=> !tempSensorEnable)
    else $error("sensor not cleared by reset");

  chk_reset_read_idle: assert property (@(posedge clk)
    resetSeen |=> (regRdData == `VRC_READ_IDLE))
    else $error("read data not idle after reset");

  chk_reset_whole_reg: assert property (@(posedge clk)
    resetSeen |=> (ctrl_ff == `VRC_RESET_REFERENCE_CONTROL))
    else $error("register not at reset value");

  // In the cycle after reset, bias is on only through a demand
  chk_reset_bias_idle: assert property (@(posedge clk)
    resetSeen ##1 noDemand |-> !biasGeneratorEnable)
    else $error("bias on after reset with no demand");

endmodule : vrc_top

/* verilog/vrc_defines.svh */
// Constants for the voltage reference control block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef VRC_DEFINES_SVH
`define VRC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define VRC_ADDR_REFERENCE_CONTROL 8'hD1
`define VRC_RESET_REFERENCE_CONTROL 8'h00
`define VRC_MASK_REFERENCE_CONTROL 8'h0E
`define VRC_READ_IDLE 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define VRC_BIT_REF_SOURCE_SELECT 3
`define VRC_BIT_TEMP_SENSOR_ENABLE 2
`define VRC_BIT_BIAS_GENERATOR_ENABLE 1

// ----------------------------------------------------------------------
// Bias demand sources: ADC, temperature sensor, internal oscillator
// ----------------------------------------------------------------------
`define VRC_BIAS_DEMANDS 3

`endif

/* verilog/vrc_pkg.sv */
// Types shared by the voltage reference control block.
// Assumes the defines header is compiled alongside.
package vrc_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [7:0] vrc_byte_type;

  // Reference source as seen by the analog mux
  typedef enum logic {
    VRC_SRC_EXT_PIN,
    VRC_SRC_SUPPLY
  } vrc_ref_source_type;

endpackage : vrc_pkg

/* verilog/vrc_bias_force.sv */
// OR of the manual bias enable with every dependent peripheral demand.
// Assumes demands are synchronous levels from the same clock domain.
`timescale 1ns/1ps

module vrc_bias_force #(
  parameter int NUM_DEMANDS = 3
) (
  input wire logic manualEnable,
  input wire logic [NUM_DEMANDS-1:0] demands,
  output logic biasOn
);

  // ----------------------------------------------------------------------
  // Forcing term
  // ----------------------------------------------------------------------
  // Any demand overrides the manual bit; purely combinational so the
  // bias follows a peripheral enable in the same cycle
  assign biasOn = manualEnable | (|demands);

endmodule : vrc_bias_force

/* dv/vrc_testbench.sv */
// Self-checking bench for the voltage reference control register.
// Assumes vrc_top with a one-cycle read port and combinational bias output.
`timescale 1ns/1ps

module testbench;
  logic clk, reset, regWrEn, regRdEn, adcEnable, oscEnable;
  logic [7:0] regAddr, regWrData, regRdData;
  logic referenceSourceSelect, tempSensorEnable, biasGeneratorEnable;
  int failCount = 0;
  int checked = 0;

  vrc_top uut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .adcEnable(adcEnable), .oscEnable(oscEnable),
    .referenceSourceSelect(referenceSourceSelect), .tempSensorEnable(tempSensorEnable),
    .biasGeneratorEnable(biasGeneratorEnable));

  // ----------------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (failCount == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // One-cycle write; outputs settle on the edge that drops the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
    end
    @(posedge clk) regWrEn <= 1'b0;
    #1;
  endtask : wr

  // Read data stands one cycle only, then returns to idle zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) begin
      regAddr <= a; regRdEn <= 1'b1;
    end
    @(posedge clk) regRdEn <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge clk) #1 chk(regRdData, 8'h00);
  endtask : rd

  // Outputs packed as {select, sensor, bias}
  task automatic outs(input logic [2:0] exp);
    chk({5'h00, referenceSourceSelect, tempSensorEnable, biasGeneratorEnable}, {5'h00, exp});
  endtask : outs

  // ----------------------------------------------------------------------
  // Watchdog: the sequence needs well under 200 cycles
  // ----------------------------------------------------------------------
  initial begin
    #10000;
    failCount++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1; regAddr = 8'h00; regWrData = 8'h00; regWrEn = 1'b0; regRdEn = 1'b0;
    adcEnable = 1'b0; oscEnable = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1 outs(3'b000);
    rd(8'hD1, 8'h00);
    wr(8'hD1, 8'hFF);
    outs(3'b111);
    rd(8'hD1, 8'h0E);
    wr(8'hD1, 8'h08);
    outs(3'b100);
    rd(8'hD1, 8'h08);
    // Unmapped place must neither store nor answer
    wr(8'hD0, 8'hFF);
    rd(8'hD0, 8'h00);
    outs(3'b100);
    // External source chosen; pin set-up stays software's duty
    wr(8'hD1, 8'hF1);
    outs(3'b000);
    // Each demand forces bias while the stored bit stays clear
    @(posedge clk) adcEnable <= 1'b1;
    #1 outs(3'b001);
    rd(8'hD1, 8'h02);
    @(posedge clk) begin
      adcEnable <= 1'b0; oscEnable <= 1'b1;
    end
    #1 outs(3'b001);
    @(posedge clk) oscEnable <= 1'b0;
    #1 outs(3'b000);
    wr(8'hD1, 8'h04);
    outs(3'b011);
    rd(8'hD1, 8'h06);
    // Manual bit survives a demand dropping away
    wr(8'hD1, 8'h02);
    @(posedge clk) adcEnable <= 1'b1;
    @(posedge clk) adcEnable <= 1'b0;
    #1 outs(3'b001);
    // Second reset clears every implemented bit
    wr(8'hD1, 8'h0E);
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    #1 outs(3'b000);
    rd(8'hD1, 8'h00);
    test_done();
  end
endmodule : testbench
